// ==== pkg/iar_cfg.svh ====
// Notes on behaviour
// - Halve sample clock, channels in opposite phase.
// - Two 12-bit output buses at half rate.
// - Output words are twos complement.
// - Strobes time capture, not the sample clock.
// - Correct offset and gain per channel, timing skew on channel B only.
// - Load configuration from nonvolatile memory at power-up.
// - Active-low reset forces a full configuration reload.
// - Outputs forced high until reload finishes.
// - Reload starts at reset release.
// - Reload ends within 87 ms of release.
// - Strobes return only after reload completes.
// - Gate input stops strobes; restart on channel A.
// - Overrange flag timed with channel B data.
`ifndef IAR_CFG_SVH
`define IAR_CFG_SVH

// Sample and buffer geometry.
`define IAR_SAMPLE_W 12
`define IAR_PAIR_W 25
`define IAR_FIFO_DEPTH 16

// Clock and timing figures in their own units.
`define IAR_CLK_PERIOD_NS 40
`define IAR_RESET_MIN_NS 200
`define IAR_RELOAD_MAX_MS 87
// Longest time, so the division rounds down.
`define IAR_RELOAD_CYCLES ((`IAR_RELOAD_MAX_MS * 1000000) / `IAR_CLK_PERIOD_NS)

// Configuration words held in nonvolatile memory.
`define IAR_CFG_ADDR_OFF_A 3'h0
`define IAR_CFG_ADDR_OFF_B 3'h1
`define IAR_CFG_ADDR_GAIN_A 3'h2
`define IAR_CFG_ADDR_GAIN_B 3'h3
`define IAR_CFG_ADDR_SKEW 3'h4
`define IAR_CFG_ADDR_LAST 3'h4

// Coefficient reset values: unity gain, no offset, no skew.
`define IAR_GAIN_RST 12'h400
`define IAR_OFF_RST 12'h000
`define IAR_SKEW_RST 12'h000
`define IAR_GAIN_SHIFT 10

// Converter code to twos complement and forced-high patterns.
`define IAR_SIGN_FLIP 12'h800
`define IAR_FORCED_HIGH 12'hfff

`endif

// ==== pkg/iar_pkg.sv ====
`include "iar_cfg.svh"

package iar_pkg;

  // Configuration reload sequencer states.
  typedef enum logic [2:0] {
    IAR_CFG_ISSUE = 3'b001,
    IAR_CFG_WAIT  = 3'b010,
    IAR_CFG_RUN   = 3'b100
  } iar_cfg_state_type;

  // Output presentation states.
  typedef enum logic [2:0] {
    IAR_OUT_IDLE = 3'b001,
    IAR_OUT_A    = 3'b010,
    IAR_OUT_B    = 3'b100
  } iar_out_state_type;

  // One corrected sample pair as it travels through the buffer.
  typedef struct packed {
    logic        ovr;
    logic [11:0] a;
    logic [11:0] b;
  } iar_pair_type;

endpackage

// ==== pkg/iar_stream_if.sv ====
`timescale 1ns/1ps

// Valid/ready stream between the capture path, the buffer and the output stage.
interface iar_stream_if #(parameter int W = 25);
  logic [W-1:0] data;   // Payload word.
  logic         valid;  // Source offers a word.
  logic         ready;  // Sink accepts it this cycle.

  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface // iar_stream_if

// ==== rtl/iar_fifo.sv ====
`timescale 1ns/1ps

module iar_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 16
) (
  input wire logic    clk,
  input wire logic    resetn,
  iar_stream_if.snk   wr,
  iar_stream_if.src   rd
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];  // Storage array.
  logic [AW-1:0]    wptr_q;         // Next write slot.
  logic [AW-1:0]    rptr_q;         // Next read slot.
  logic [AW:0]      count_q;        // Words held in the array.
  logic [WIDTH-1:0] out_q;          // Registered read data.
  logic             out_v_q;        // Read register holds a word.
  logic             push;
  logic             fetch;

  // Full is honest: the array alone is counted, the read register is extra.
  assign wr.ready = (count_q != (AW+1)'(DEPTH));
  assign push     = wr.valid && wr.ready;
  // Refill the read register when empty or being drained.
  assign fetch    = (count_q != '0) && (!out_v_q || rd.ready);
  assign rd.data  = out_q;
  assign rd.valid = out_v_q;

  // The array has no reset; pointers, count and read valid carry the control state.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wptr_q] <= wr.data;
    end
  end

  // Pointer and occupancy bookkeeping.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wptr_q  <= '0;
      rptr_q  <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wptr_q <= wptr_q + 1'b1;
      end
      if (fetch) begin
        rptr_q <= rptr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(fetch);
    end
  end

  // Read register, so the drain side sees flip-flop outputs.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_q   <= '0;
      out_v_q <= 1'b0;
    end else if (fetch) begin
      out_q   <= mem_q[rptr_q];
      out_v_q <= 1'b1;
    end else if (rd.ready) begin
      out_v_q <= 1'b0;
    end
  end
endmodule // iar_fifo

// ==== rtl/iar_top.sv ====
`timescale 1ns/1ps
`include "iar_cfg.svh"

module iar_top
  import iar_pkg::*;
#(
  parameter int unsigned RELOAD_CYCLES = `IAR_RELOAD_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [11:0] chan_a_raw,
  input  wire logic [11:0] chan_b_raw,
  input  wire logic        ovr_a_raw,
  input  wire logic        ovr_b_raw,
  input  wire logic        strobe_gate_enable,
  input  wire logic [15:0] nvm_rd_data,
  input  wire logic        nvm_rd_valid,
  output logic             chan_a_conv_clk,
  output logic             chan_b_conv_clk,
  output logic             nvm_rd_req,
  output logic [2:0]       nvm_addr,
  output logic [11:0]      chan_a_data,
  output logic [11:0]      chan_b_data,
  output logic             chan_a_data_strobe,
  output logic             chan_b_data_strobe,
  output logic             overrange_flag,
  output logic             cfg_done
);

  iar_cfg_state_type cfg_q;          // Reload sequencer state.
  iar_out_state_type out_q;          // Output presentation state.
  logic [21:0]       timer_q;        // Cycles since reset release.
  logic [2:0]        addr_q;         // Configuration word being fetched.
  logic              req_q;          // Read request pulse to the memory.
  logic [11:0]       off_a_q;        // Channel A offset.
  logic [11:0]       off_b_q;        // Channel B offset.
  logic [11:0]       gain_a_q;       // Channel A gain, 1.0 at 0x400.
  logic [11:0]       gain_b_q;       // Channel B gain.
  logic [11:0]       skew_q;         // Clock-timing skew weight.
  logic              conv_a_q;       // Halved clock for channel A.
  logic              conv_b_q;       // Halved clock for channel B.
  logic [11:0]       a_s_q;          // Last channel A sample, twos complement.
  logic [11:0]       a_prev_q;       // The A sample before that.
  logic              ovr_a_q;        // Overrange seen on the held A sample.
  iar_pair_type      pair_q;         // Corrected pair awaiting the buffer.
  logic              pair_v_q;       // Pair register is occupied.
  iar_pair_type      hold_q;         // Pair being presented on the pins.
  logic              gate_s1_q;      // Gate synchroniser, first stage.
  logic              gate_s2_q;      // Gate synchroniser, second stage.
  logic              gate_s3_q;      // Gate synchroniser, third stage.
  logic              gate_on_q;      // Debounced gate level.
  logic [11:0]       b_s;            // Current channel B sample, twos complement.
  logic [12:0]       a_diff;         // A slope used for skew correction.
  logic signed [24:0] skew_prod;     // Slope times skew weight.
  logic              running;        // Reload has finished or timed out.
  logic              pop;            // Output stage takes a pair.
  logic              last_word;      // Fetching the final configuration word.
  logic              timeout;        // Reload deadline reached.

  iar_stream_if #(.W(`IAR_PAIR_W)) push_if ();
  iar_stream_if #(.W(`IAR_PAIR_W)) pop_if ();

  // Correct one sample: remove offset, add skew term, scale, saturate.
  function automatic logic [11:0] iar_corr(input logic signed [11:0] s,
                                           input logic signed [11:0] off,
                                           input logic signed [11:0] gain,
                                           input logic signed [12:0] adj);
    logic signed [13:0] c;
    logic signed [27:0] p;
    c = 14'(s) - 14'(off) + 14'(adj);
    p = (28'(c) * 28'(gain)) >>> `IAR_GAIN_SHIFT;
    if (p > 28'sd2047) begin
      return 12'h7ff;
    end else if (p < -28'sd2048) begin
      return 12'h800;
    end else begin
      return p[11:0];
    end
  endfunction

  assign running   = (cfg_q == IAR_CFG_RUN);
  assign last_word = (addr_q == `IAR_CFG_ADDR_LAST);
  assign timeout   = (timer_q == 22'(RELOAD_CYCLES - 1));
  assign cfg_done  = running;
  assign nvm_rd_req = req_q;
  assign nvm_addr   = addr_q;
  assign chan_a_conv_clk = conv_a_q;
  assign chan_b_conv_clk = conv_b_q;

  // Reload sequencer, also entered at power-up.
  // Async reset parks it in ISSUE, so fetching begins at release.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_q  <= IAR_CFG_ISSUE;
      addr_q <= 3'h0;
      req_q  <= 1'b0;
    end else begin
      req_q <= 1'b0;
      case (cfg_q)
        IAR_CFG_ISSUE: begin
          req_q <= 1'b1;
          cfg_q <= IAR_CFG_WAIT;
        end
        IAR_CFG_WAIT: begin
          if (nvm_rd_valid && last_word) begin
            cfg_q <= IAR_CFG_RUN;
          end else if (nvm_rd_valid) begin
            addr_q <= addr_q + 3'h1;
            cfg_q  <= IAR_CFG_ISSUE;
          end
        end
        IAR_CFG_RUN: begin
          cfg_q <= IAR_CFG_RUN;
        end
        default: begin
          cfg_q <= IAR_CFG_ISSUE;
        end
      endcase
      // A silent memory must not hold the device off for ever.
      if (!running && timeout) begin
        cfg_q <= IAR_CFG_RUN;
      end
    end
  end

  // Deadline counter; it stops once the block is running.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timer_q <= 22'h000000;
    end else if (!running) begin
      timer_q <= timer_q + 22'h000001;
    end
  end

  // Reset returns coefficients to defaults before the reload.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      off_a_q  <= `IAR_OFF_RST;
      off_b_q  <= `IAR_OFF_RST;
      gain_a_q <= `IAR_GAIN_RST;
      gain_b_q <= `IAR_GAIN_RST;
      skew_q   <= `IAR_SKEW_RST;
    end else if (cfg_q == IAR_CFG_WAIT && nvm_rd_valid) begin
      case (addr_q)
        `IAR_CFG_ADDR_OFF_A:  off_a_q  <= nvm_rd_data[11:0];
        `IAR_CFG_ADDR_OFF_B:  off_b_q  <= nvm_rd_data[11:0];
        `IAR_CFG_ADDR_GAIN_A: gain_a_q <= nvm_rd_data[11:0];
        `IAR_CFG_ADDR_GAIN_B: gain_b_q <= nvm_rd_data[11:0];
        `IAR_CFG_ADDR_SKEW:   skew_q   <= nvm_rd_data[11:0];
        default:              skew_q   <= skew_q;
      endcase
    end
  end

  // Divide by two; the two clocks are always complements.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      conv_a_q <= 1'b0;
      conv_b_q <= 1'b1;
    end else begin
      conv_a_q <= ~conv_a_q;
      conv_b_q <= ~conv_b_q;
    end
  end

  // Flip the sign bit to turn converter code into twos complement.
  assign b_s       = chan_b_raw ^ `IAR_SIGN_FLIP;
  assign a_diff    = 13'($signed(a_s_q) - $signed(a_prev_q));
  assign skew_prod = 25'($signed(a_diff) * $signed(skew_q));

  // Channel A is taken while its halved clock is high, B on the other half.
  // A full buffer stalls capture; samples arriving then are lost.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      a_s_q    <= 12'h000;
      a_prev_q <= 12'h000;
      ovr_a_q  <= 1'b0;
      pair_q   <= '0;
      pair_v_q <= 1'b0;
    end else begin
      if (push_if.ready) begin
        pair_v_q <= 1'b0;
      end
      if (conv_a_q) begin
        a_prev_q <= a_s_q;
        a_s_q    <= chan_a_raw ^ `IAR_SIGN_FLIP;
        ovr_a_q  <= ovr_a_raw;
      end else if (running && (!pair_v_q || push_if.ready)) begin
        // Gain and offset per channel, timing skew on B.
        pair_q.a <= iar_corr(a_s_q, off_a_q, gain_a_q, 13'sd0);
        pair_q.b <= iar_corr(b_s, off_b_q, gain_b_q,
                             13'(skew_prod >>> `IAR_GAIN_SHIFT));
        // Flag covers this B sample and the A before it.
        pair_q.ovr <= ovr_a_q | ovr_b_raw;
        pair_v_q   <= 1'b1;
      end
    end
  end

  assign push_if.data  = pair_q;
  assign push_if.valid = pair_v_q;

  iar_fifo #(
    .WIDTH (`IAR_PAIR_W),
    .DEPTH (`IAR_FIFO_DEPTH)
  ) u_fifo (
    .clk    (clk),
    .resetn (resetn),
    .wr     (push_if),
    .rd     (pop_if)
  );

  // Gate pin passes three stages; a change counts once stages two and three agree.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gate_s1_q <= 1'b0;
      gate_s2_q <= 1'b0;
      gate_s3_q <= 1'b0;
      gate_on_q <= 1'b0;
    end else begin
      gate_s1_q <= strobe_gate_enable;
      gate_s2_q <= gate_s1_q;
      gate_s3_q <= gate_s2_q;
      if (gate_s2_q == gate_s3_q) begin
        gate_on_q <= gate_s3_q;
      end
    end
  end

  // New pairs start only with the gate open, so restart is on A.
  assign pop = running && gate_on_q && pop_if.valid && (out_q != IAR_OUT_A);
  assign pop_if.ready = pop;

  // Each bus updates once per pair, half the sample clock rate.
  // Strobes rise with their data, each for one cycle; capture is timed by them.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      // Forced high while reset is held.
      out_q              <= IAR_OUT_IDLE;
      hold_q             <= '0;
      chan_a_data        <= `IAR_FORCED_HIGH;
      chan_b_data        <= `IAR_FORCED_HIGH;
      chan_a_data_strobe <= 1'b1;
      chan_b_data_strobe <= 1'b1;
      overrange_flag     <= 1'b1;
    end else if (!running) begin
      // Still forced high until the reload has finished.
      out_q              <= IAR_OUT_IDLE;
      chan_a_data        <= `IAR_FORCED_HIGH;
      chan_b_data        <= `IAR_FORCED_HIGH;
      chan_a_data_strobe <= 1'b1;
      chan_b_data_strobe <= 1'b1;
      overrange_flag     <= 1'b1;
    end else if (!gate_on_q) begin
      // Closed gate stops both strobes; a half-shown pair is dropped.
      out_q              <= IAR_OUT_IDLE;
      chan_a_data_strobe <= 1'b0;
      chan_b_data_strobe <= 1'b0;
    end else begin
      // Strobe pulses start only from here, after the reload.
      chan_a_data_strobe <= 1'b0;
      chan_b_data_strobe <= 1'b0;
      case (out_q)
        IAR_OUT_IDLE, IAR_OUT_B: begin
          if (pop) begin
            hold_q             <= pop_if.data;
            chan_a_data        <= pop_if.data[23:12];
            chan_a_data_strobe <= 1'b1;
            out_q              <= IAR_OUT_A;
          end else begin
            out_q <= IAR_OUT_IDLE;
          end
        end
        IAR_OUT_A: begin
          // Flag moves together with the B word.
          chan_b_data        <= hold_q.b;
          overrange_flag     <= hold_q.ovr;
          chan_b_data_strobe <= 1'b1;
          out_q              <= IAR_OUT_B;
        end
        default: begin
          out_q <= IAR_OUT_IDLE;
        end
      endcase
    end
  end
endmodule // iar_top

// ==== sim/iar_assertions.sv ====
`timescale 1ns/1ps

// Watches the top ports for the output, strobe and reload rules.
module iar_assertions #(
  parameter int unsigned RELOAD_CYCLES = 64
) (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        strobe_gate_enable,
  input wire logic        chan_a_conv_clk,
  input wire logic        chan_b_conv_clk,
  input wire logic        nvm_rd_req,
  input wire logic [2:0]  nvm_addr,
  input wire logic [11:0] chan_a_data,
  input wire logic [11:0] chan_b_data,
  input wire logic        chan_a_data_strobe,
  input wire logic        chan_b_data_strobe,
  input wire logic        overrange_flag,
  input wire logic        cfg_done
);
  logic [3:0]  gate_hi_q;  // Cycles the gate input has stayed high.
  logic [3:0]  gate_lo_q;  // Cycles the gate input has stayed low.
  logic [31:0] rel_q;      // Cycles spent reloading since release.

  // Saturating history, so the synchroniser lag of the gate never trips a check.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gate_hi_q <= 4'h0;
      gate_lo_q <= 4'h0;
    end else begin
      gate_hi_q <= !strobe_gate_enable ? 4'h0 : gate_hi_q + 4'(gate_hi_q != 4'hf);
      gate_lo_q <= strobe_gate_enable ? 4'h0 : gate_lo_q + 4'(gate_lo_q != 4'hf);
    end
  end

  // Reload time counts from release until done.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rel_q <= 32'h0;
    end else begin
      rel_q <= cfg_done ? 32'h0 : rel_q + 32'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // An A word strobed, then its B word one cycle later.
  sequence s_pair;
    chan_a_data_strobe ##1 (chan_b_data_strobe && !chan_a_data_strobe);
  endsequence

  a_conv_opposite: assert property (chan_a_conv_clk != chan_b_conv_clk)
    else $error("conversion clocks not in opposite phase");
  a_conv_halved: assert property ($past(resetn) |-> $changed(chan_a_conv_clk))
    else $error("channel clock did not toggle");
  a_forced_high: assert property (!cfg_done |-> chan_a_data == 12'hfff &&
    chan_b_data == 12'hfff && chan_a_data_strobe && chan_b_data_strobe && overrange_flag)
    else $error("outputs not forced high during reload");
  a_reload_start: assert property ($rose(resetn) |->
    ##[1:3] (nvm_rd_req && nvm_addr == 3'h0))
    else $error("reload did not start at release");
  a_reload_bound: assert property (rel_q <= RELOAD_CYCLES + 2)
    else $error("reload ran too long");
  // The first running cycle still shows the forced-high strobes, so it is left out.
  a_strobe_pair: assert property (cfg_done && $past(cfg_done) && chan_a_data_strobe &&
    gate_hi_q >= 4'h6 |-> s_pair)
    else $error("B strobe did not follow A strobe");
  a_b_after_a: assert property (cfg_done && chan_b_data_strobe |-> $past(chan_a_data_strobe))
    else $error("B strobe without preceding A strobe");
  a_gate_stops: assert property (cfg_done && $past(cfg_done) && gate_lo_q >= 4'h6 |->
    !chan_a_data_strobe && !chan_b_data_strobe)
    else $error("strobes while gate held low");
  a_a_with_strobe: assert property (cfg_done && $past(cfg_done) && $changed(chan_a_data)
    |-> chan_a_data_strobe)
    else $error("A word changed without its strobe");
  a_flag_with_b: assert property (cfg_done && $past(cfg_done) &&
    ($changed(chan_b_data) || $changed(overrange_flag)) |-> chan_b_data_strobe)
    else $error("B word or flag changed without B strobe");
endmodule // iar_assertions

bind iar_top iar_assertions #(.RELOAD_CYCLES(RELOAD_CYCLES)) u_chk (
  .clk(clk), .resetn(resetn), .strobe_gate_enable(strobe_gate_enable),
  .chan_a_conv_clk(chan_a_conv_clk), .chan_b_conv_clk(chan_b_conv_clk),
  .nvm_rd_req(nvm_rd_req), .nvm_addr(nvm_addr), .chan_a_data(chan_a_data),
  .chan_b_data(chan_b_data), .chan_a_data_strobe(chan_a_data_strobe),
  .chan_b_data_strobe(chan_b_data_strobe), .overrange_flag(overrange_flag),
  .cfg_done(cfg_done));

// ==== sim/iar_capture_model.sv ====
`timescale 1ns/1ps

// Capture logic on the far side: pairs an A word with the B word after it.
module iar_capture_model (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [11:0] chan_a_data,
  input wire logic [11:0] chan_b_data,
  input wire logic        chan_a_data_strobe,
  input wire logic        chan_b_data_strobe,
  input wire logic        overrange_flag,
  output logic [11:0]     got_a,
  output logic [11:0]     got_b,
  output logic            got_ovr,
  output logic [15:0]     n_pairs
);
  logic [11:0] a_q;     // A word awaiting its partner.
  logic        have_a_q; // An A word is held.
  logic        forced;   // Outputs show the reload pattern.

  assign forced = chan_a_data_strobe && chan_b_data_strobe &&
                  chan_a_data == 12'hfff && chan_b_data == 12'hfff;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      a_q <= 12'h000;
      have_a_q <= 1'b0;
      got_a <= 12'h000;
      got_b <= 12'h000;
      got_ovr <= 1'b0;
      n_pairs <= 16'h0000;
    end else if (forced) begin
      // Reload words are dropped and pairing starts over.
      have_a_q <= 1'b0;
    end else if (chan_a_data_strobe) begin
      a_q <= chan_a_data;
      have_a_q <= 1'b1;
    end else if (chan_b_data_strobe && have_a_q) begin
      got_a <= a_q;
      got_b <= chan_b_data;
      got_ovr <= overrange_flag;
      n_pairs <= n_pairs + 16'h0001;
      have_a_q <= 1'b0;
    end
  end
endmodule // iar_capture_model

// ==== sim/testbench.sv ====
`timescale 1ns/1ps

`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end

module testbench;
  // One constant input row and the pair it should give.
  typedef struct packed {
    logic [11:0] a_raw;
    logic [11:0] b_raw;
    logic        ovr_a;
    logic        ovr_b;
    logic [11:0] exp_a;
    logic [11:0] exp_b;
    logic        exp_ovr;
  } iar_row_type;

  logic clk, resetn, gate, ovr_a, ovr_b, nvm_valid, mute;
  logic [11:0] a_raw, b_raw, got_a, got_b, a_d, b_d;
  logic [15:0] nvm_data, n_pairs, p;
  logic        a_stb, b_stb, ovr_f, done, got_ovr, req;
  logic [2:0]  addr;
  int          n_fail, n_compared, cyc, took;
  // Offsets A=+16, B=-16, gain A=0.5, gain B=1.0, no skew.
  logic [11:0] cfg_word [5] = '{12'h010, 12'hff0, 12'h200, 12'h400, 12'h000};
  iar_row_type rows [4] = '{
    '{12'h800, 12'h800, 1'b0, 1'b0, 12'hff8, 12'h010, 1'b0},
    '{12'hfff, 12'hfff, 1'b1, 1'b0, 12'h3f7, 12'h7ff, 1'b1},
    '{12'h000, 12'h000, 1'b0, 1'b1, 12'hbf8, 12'h810, 1'b1},
    '{12'h9a5, 12'h123, 1'b0, 1'b0, 12'h0ca, 12'h933, 1'b0}};

  iar_top #(.RELOAD_CYCLES(64)) uut (
    .clk(clk), .resetn(resetn), .chan_a_raw(a_raw), .chan_b_raw(b_raw),
    .ovr_a_raw(ovr_a), .ovr_b_raw(ovr_b), .strobe_gate_enable(gate),
    .nvm_rd_data(nvm_data), .nvm_rd_valid(nvm_valid), .chan_a_conv_clk(),
    .chan_b_conv_clk(), .nvm_rd_req(req), .nvm_addr(addr), .chan_a_data(a_d),
    .chan_b_data(b_d), .chan_a_data_strobe(a_stb), .chan_b_data_strobe(b_stb),
    .overrange_flag(ovr_f), .cfg_done(done));

  iar_capture_model u_cap (
    .clk(clk), .resetn(resetn), .chan_a_data(a_d), .chan_b_data(b_d),
    .chan_a_data_strobe(a_stb), .chan_b_data_strobe(b_stb), .overrange_flag(ovr_f),
    .got_a(got_a), .got_b(got_b), .got_ovr(got_ovr), .n_pairs(n_pairs));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Memory answers at the edge after a request, unless muted to force the timeout.
  // The request is read just after the edge, once the design has settled it.
  always @(posedge clk) begin
    #1;
    nvm_valid = req && !mute;
    nvm_data = {4'h0, cfg_word[addr]};
  end

  // Ceiling well above the expected run of some 520 cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      summarize();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // hold reset, then time the reload.
  task automatic reload(input int hold);
    resetn = 1'b0;
    tick(hold);
    resetn = 1'b1;
    took = 0;
    while (done !== 1'b1 && took < 200) begin
      tick(1);
      took++;
      if (took == 2) `CHK({a_d, b_d, a_stb, b_stb, ovr_f}, 27'h7ffffff)
    end
  endtask

  task automatic summarize();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    {resetn, gate, ovr_a, ovr_b, mute, a_raw, b_raw} = '0;
    gate = 1'b1;
    reload(3);
    `CHK(done, 1'b1)
    foreach (rows[i]) begin
      {a_raw, b_raw, ovr_a, ovr_b} = {rows[i].a_raw, rows[i].b_raw, rows[i].ovr_a, rows[i].ovr_b};
      tick(60);
      `CHK(got_a, rows[i].exp_a)
      `CHK(got_b, rows[i].exp_b)
      `CHK(got_ovr, rows[i].exp_ovr)
    end
    gate = 1'b0;
    tick(10);
    p = n_pairs;
    tick(60);
    `CHK(n_pairs, p)
    gate = 1'b1;
    took = 0;
    while (a_stb !== 1'b1 && took < 20) begin
      tick(1);
      took++;
    end
    `CHK(a_stb, 1'b1)
    tick(1);
    `CHK(b_stb, 1'b1)
    tick(60);
    `CHK(got_a, rows[3].exp_a)
    mute = 1'b1;
    reload(5);
    `CHK(took >= 60 && took <= 68, 1'b1)
    mute = 1'b0;
    tick(60);
    `CHK(got_a, 12'h1a5)
    `CHK(got_b, 12'h923)
    summarize();
  end
endmodule // testbench
